// ---- sim/bias_sys_regs_props.sv ----
// Purpose: Decode and write checks on the bias and control bank
// Assumes: Byte addresses 20h, 24h, 28h; one clock domain
// Notes: Decode flops lag the register by one clock
`timescale 1ns/1ps
`default_nettype none
module bias_sys_regs_props (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire bias_to_input0,
  input wire bias_to_input1,
  input wire bias_to_input2,
  input wire bias_to_input3,
  input wire bias_to_input4,
  input wire bias_to_input5,
  input wire bias_to_common_input,
  input wire mid_supply_short,
  input wire temp_sensor_route,
  input wire analog_supply_monitor,
  input wire digital_supply_monitor,
  input wire input_mux_open,
  input wire burnout_enable,
  input wire amplifier_enable_required,
  input wire [2:0] effective_gain_code,
  input wire [4:0] calibration_sample_count,
  input wire serial_timeout_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completing transfers, reads or writes; a strobe-less write would not commit
  sequence s_done;
    psel && penable && pready && ce;
  endsequence
  sequence s_bias_wr;
    s_done ##0 (pwrite && pstrb[0] && paddr == 8'h20);
  endsequence
  sequence s_ctrl_wr;
    s_done ##0 (pwrite && pstrb[0] && paddr == 8'h24);
  endsequence
  property p_bias_wr;
    s_bias_wr |-> ##2 {bias_to_common_input, bias_to_input5, bias_to_input4,
      bias_to_input3, bias_to_input2, bias_to_input1, bias_to_input0}
      == $past(pwdata[6:0], 2);
  endproperty
  a_bias_wr: assert property (p_bias_wr)
    else $error("bias outputs differ from write");
  property p_timeout_wr;
    s_ctrl_wr |-> ##2 serial_timeout_enable == $past(pwdata[2], 2);
  endproperty
  a_timeout_wr: assert property (p_timeout_wr)
    else $error("timeout enable differs from write");
  property p_cal_wr;
    s_ctrl_wr |-> ##2 calibration_sample_count ==
      ($past(pwdata[4:3], 2) == 2'h0 ? 5'h01 : 5'h02 << $past(pwdata[4:3], 2));
  endproperty
  a_cal_wr: assert property (p_cal_wr)
    else $error("sample count differs from write");
  property p_mux_open;
    input_mux_open == (mid_supply_short || temp_sensor_route ||
      analog_supply_monitor || digital_supply_monitor);
  endproperty
  a_mux_open: assert property (p_mux_open)
    else $error("input mux state wrong");
  property p_mon_onehot;
    $onehot0({mid_supply_short, temp_sensor_route, analog_supply_monitor,
      digital_supply_monitor, burnout_enable});
  endproperty
  a_mon_onehot: assert property (p_mon_onehot)
    else $error("more than one monitor mode active");
  property p_gain_forced;
    analog_supply_monitor || digital_supply_monitor |->
      effective_gain_code == 3'h0;
  endproperty
  a_gain_forced: assert property (p_gain_forced)
    else $error("gain not forced to one");
  property p_temp_amp;
    temp_sensor_route == amplifier_enable_required;
  endproperty
  a_temp_amp: assert property (p_temp_amp)
    else $error("amplifier request wrong");
  property p_rsvd_read;
    s_done ##0 (!pwrite && paddr == 8'h28) |-> prdata == 32'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved location not zero");
endmodule
bind bias_sys_regs bias_sys_regs_props chk (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .bias_to_input0, .bias_to_input1, .bias_to_input2, .bias_to_input3,
  .bias_to_input4, .bias_to_input5, .bias_to_common_input,
  .mid_supply_short, .temp_sensor_route, .analog_supply_monitor,
  .digital_supply_monitor, .input_mux_open, .burnout_enable,
  .amplifier_enable_required, .effective_gain_code,
  .calibration_sample_count, .serial_timeout_enable);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Register and decode tests of the bias and control bank
// Assumes: Clock enable held high throughout
// Notes: APB master releases psel after each transfer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, i;
  logic [1:0] amplifier_enable, burnout_level;
  logic [2:0] gain_code, effective_gain_code;
  logic [4:0] calibration_sample_count;
  logic [6:0] bias;
  logic mid, tmp, asup, dsup, mux, burn, areq, tout, fault;
  int miscompares, samples_checked;
  bias_sys_regs uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amplifier_enable(amplifier_enable), .gain_code(gain_code),
    .bias_to_input0(bias[0]), .bias_to_input1(bias[1]),
    .bias_to_input2(bias[2]), .bias_to_input3(bias[3]),
    .bias_to_input4(bias[4]), .bias_to_input5(bias[5]),
    .bias_to_common_input(bias[6]), .mid_supply_short(mid),
    .temp_sensor_route(tmp), .analog_supply_monitor(asup),
    .digital_supply_monitor(dsup), .input_mux_open(mux),
    .burnout_enable(burn), .burnout_level(burnout_level),
    .amplifier_enable_required(areq),
    .effective_gain_code(effective_gain_code),
    .calibration_sample_count(calibration_sample_count),
    .serial_timeout_enable(tout), .temp_config_fault(fault));
  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One transfer; the request stands until the edge that sees pready high,
  // and only the watchdog ends a wait that never gets an answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ce, pstrb, amplifier_enable, gain_code} = {1'b1, 4'hf, 2'h0, 3'h5};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check({calibration_sample_count, tout}, {5'h08, 1'b0});
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 8'h20 + {2'b00, i, 2'b00}, 32'h0);
      check(rd, i == 1 ? 32'h10 : 32'h0);
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 8'h20, i[0] ? 32'h2a : 32'h55);
      apb(1'b0, 8'h20, 32'h0);
      check(rd, i[0] ? 32'h2a : 32'h55);
      check(bias, i[0] ? 7'h2a : 7'h55);
    end
    // A write with its low strobe lane off must leave the bias word alone
    pstrb <= 4'h0;
    apb(1'b1, 8'h20, 32'h7f);
    pstrb <= 4'hf;
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h2a);
    // Every monitor code, with sample codes and timeout riding along
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'h24, {24'h0, i[2:0], i[1:0], i[0], 2'b00});
      apb(1'b0, 8'h24, 32'h0);
      check(rd, {24'h0, i[2:0], i[1:0], i[0], 2'b00});
      check({mid, tmp, asup, dsup, mux, burn, areq, effective_gain_code,
        calibration_sample_count, tout, fault}, {i == 1, i == 2, i == 3,
        i == 4, i >= 1 && i <= 4, i >= 5, i == 2,
        (i == 3 || i == 4) ? 3'h0 : 3'h5,
        i[1:0] == 0 ? 5'h01 : 5'h02 << i[1:0],
        i[0], i == 2});
      if (i >= 5) check(burnout_level, i[1:0] - 2'h1);
    end
    amplifier_enable <= 2'h1;
    gain_code <= 3'h2;
    apb(1'b1, 8'h24, 32'h50);
    apb(1'b0, 8'h24, 32'h0);
    check({fault, effective_gain_code}, {1'b0, 3'h2});
    apb(1'b0, 8'hc0, 32'h0);
    check(rd, 32'h4);
    gain_code <= 3'h3;
    apb(1'b0, 8'hc0, 32'h0);
    check({rd[30:0], fault}, {31'h6, 1'b1});
    apb(1'b1, 8'h28, 32'hff);
    apb(1'b0, 8'h28, 32'h0);
    check({er, rd[30:0]}, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    // Reset in mid-run must bring both words back to their defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h24, 32'h0);
    check({rd[23:0], tout, bias}, {24'h10, 1'b0, 7'h00});
    complete_run;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire

// ---- verilog/bias_sys_consts.vh ----
// Purpose: Constants for the bias and system control register bank
// Assumes: Register indices are word indices; byte address is 4x index
// Notes: Included by the bank top only; the register slice does not include it
`ifndef BIAS_SYS_CONSTS_VH
`define BIAS_SYS_CONSTS_VH

// Register indices (byte address = index * 4)
`define IDX_SENSOR_BIAS 6'h08
`define IDX_SYS_CTRL 6'h09
`define IDX_RSVD_A 6'h0a
`define IDX_STATUS 6'h30

// Reset values
`define RST_SENSOR_BIAS 8'h00
`define RST_SYS_CTRL 8'h10
`define RST_RSVD_A 8'h00

// Sensor bias fields
`define BIAS_COMMON_BIT 6
`define BIAS_RSVD_BIT 7

// System control fields
`define MON_HI 7
`define MON_LO 5
`define CAL_HI 4
`define CAL_LO 3
`define TIMEOUT_BIT 2

// Monitor select codes
`define MON_OFF 3'h0
`define MON_MID_SHORT 3'h1
`define MON_TEMP 3'h2
`define MON_ANALOG_SUP 3'h3
`define MON_DIGITAL_SUP 3'h4
`define MON_BURN_LOW 3'h5
`define MON_BURN_MID 3'h6
`define MON_BURN_HIGH 3'h7

// Burn-out level encodings on the level output
`define BURN_LVL_0U2 2'h0
`define BURN_LVL_1U 2'h1
`define BURN_LVL_10U 2'h2

// Calibration sample codes and counts
`define CAL_CODE_1 2'h0
`define CAL_CODE_4 2'h1
`define CAL_CODE_8 2'h2
`define CAL_CODE_16 2'h3
`define CAL_CNT_1 5'h01
`define CAL_CNT_4 5'h04
`define CAL_CNT_8 5'h08
`define CAL_CNT_16 5'h10

// Amplifier settings
`define AMP_EN_TEMP 2'h1
`define GAIN_CODE_ONE 3'h0
`define GAIN_CODE_MAX_TEMP 3'h2

// Status register bits
`define ST_TEMP_AMP_BIT 0
`define ST_TEMP_GAIN_BIT 1
`define ST_MUX_OPEN_BIT 2
`define ST_GAIN_FORCED_BIT 3

`endif

// ---- verilog/bias_sys_regs.v ----
// Purpose: APB register bank for sensor bias and system monitor control
// Assumes: Amplifier settings arrive from logic on the same clock
// Notes: Decoded outputs lag a register write by one clock
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bias_sys_consts.vh"

// Operation
// - Bias register resets zero, bit per input
// - Any bias bit combination may be set
// - Control register resets 10h, samples code 2
// - Monitor 000 off, 001 mid-supply short
// - Monitor 010 temperature needs amplifier enable 01
// - Supply monitors force amplifier gain to one
// - Codes 101-111 enable burn-out current sources
// - Short, temperature, supply monitors open input mux
// - Sample field selects 1, 4, 8, 16
// - Bit 2 enables serial timeout, reset off
// - Reserved location reads zero, ignores writes
module bias_sys_regs (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] amplifier_enable,
  input wire [2:0] gain_code,
  output reg bias_to_input0,
  output reg bias_to_input1,
  output reg bias_to_input2,
  output reg bias_to_input3,
  output reg bias_to_input4,
  output reg bias_to_input5,
  output reg bias_to_common_input,
  output reg mid_supply_short,
  output reg temp_sensor_route,
  output reg analog_supply_monitor,
  output reg digital_supply_monitor,
  output reg input_mux_open,
  output reg burnout_enable,
  output reg [1:0] burnout_level,
  output reg amplifier_enable_required,
  output reg [2:0] effective_gain_code,
  output reg [4:0] calibration_sample_count,
  output reg serial_timeout_enable,
  output reg temp_config_fault
);

  // Address decode
  wire [5:0] idx;
  wire word_aligned;
  wire hit_bias;
  wire hit_sys;
  wire hit_rsvd;
  wire hit_status;
  wire hit_any;
  wire addr_error;

  // Handshake
  wire start;
  wire done;
  wire we_bias;
  wire we_sys;

  // Register contents
  wire [7:0] bias_q;
  wire [7:0] sys_q;
  wire [2:0] monitor_select;
  wire [1:0] cal_code;
  wire timeout_bit;

  // Decoded next values
  reg mid_short_d;
  reg temp_d;
  reg asup_d;
  reg dsup_d;
  reg burn_en_d;
  reg [1:0] burn_lvl_d;
  reg [4:0] cal_cnt_d;
  reg [2:0] gain_d;
  reg temp_amp_bad_d;
  reg temp_gain_bad_d;
  reg [31:0] rdata_d;

  // Status bits held as flops so reads see settled state
  reg temp_amp_bad_q;
  reg temp_gain_bad_q;

  // Status word; its layout is kept apart from the read mux
  reg [31:0] status_word;

  // Word index from the byte address; the low two bits must be zero
  assign idx = paddr[7:2];
  assign word_aligned = (paddr[1:0] == 2'h0);
  assign hit_bias = word_aligned && (idx == `IDX_SENSOR_BIAS);
  assign hit_sys = word_aligned && (idx == `IDX_SYS_CTRL);
  assign hit_rsvd = word_aligned && (idx == `IDX_RSVD_A);
  assign hit_status = word_aligned && (idx == `IDX_STATUS);
  assign hit_any = hit_bias || hit_sys || hit_rsvd || hit_status;
  // Misaligned or unmapped words answer with an error and no effect
  assign addr_error = !hit_any;

  // The answer is prepared on any edge where psel is up and pready is
  // still low, so a clock-enable gap during setup cannot strand it
  assign start = psel && !pready;
  // Writes commit only at the edge where the master sees pready high
  assign done = psel && penable && pready;
  // Each register is one byte, so only the lowest strobe lane counts
  assign we_bias = done && pwrite && hit_bias && pstrb[0];
  assign we_sys = done && pwrite && hit_sys && pstrb[0];

  // Bias register: every bit independent, any mix may be set
  // Reserved bit 7 is plain storage; software keeps it at zero
  ctrl_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_SENSOR_BIAS)
  ) u_bias_reg (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(we_bias),
    .wdata(pwdata[7:0]),
    .value_q(bias_q)
  );

  // System control register
  // Reserved bits 1:0 are plain storage as well
  ctrl_reg #(
    .WIDTH(8),
    .RESET_VALUE(`RST_SYS_CTRL)
  ) u_sys_reg (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(we_sys),
    .wdata(pwdata[7:0]),
    .value_q(sys_q)
  );

  // Field slices of the control word
  assign monitor_select = sys_q[`MON_HI:`MON_LO];
  assign cal_code = sys_q[`CAL_HI:`CAL_LO];
  assign timeout_bit = sys_q[`TIMEOUT_BIT];

  // Monitor select decode into one-hot controls for the analog side
  // Codes 101-111 leave the mux closed: the sources must reach the pins
  always @* begin
    mid_short_d = 1'b0;
    temp_d = 1'b0;
    asup_d = 1'b0;
    dsup_d = 1'b0;
    burn_en_d = 1'b0;
    burn_lvl_d = `BURN_LVL_0U2;
    case (monitor_select)
      `MON_OFF: begin
        mid_short_d = 1'b0;
      end
      `MON_MID_SHORT: begin
        mid_short_d = 1'b1;
      end
      `MON_TEMP: begin
        temp_d = 1'b1;
      end
      `MON_ANALOG_SUP: begin
        asup_d = 1'b1;
      end
      `MON_DIGITAL_SUP: begin
        dsup_d = 1'b1;
      end
      // Burn-out codes only switch the sources, in rising current order
      `MON_BURN_LOW: begin
        burn_en_d = 1'b1;
        burn_lvl_d = `BURN_LVL_0U2;
      end
      `MON_BURN_MID: begin
        burn_en_d = 1'b1;
        burn_lvl_d = `BURN_LVL_1U;
      end
      `MON_BURN_HIGH: begin
        burn_en_d = 1'b1;
        burn_lvl_d = `BURN_LVL_10U;
      end
      default: begin
        burn_en_d = 1'b0;
      end
    endcase
  end

  // Gain: user setting except supply monitors, which ignore it
  // Temperature mode keeps the user gain; too high a gain is flagged
  // below rather than clamped, since clamping would hide the error
  always @* begin
    if (asup_d || dsup_d) begin
      gain_d = `GAIN_CODE_ONE;
    end else begin
      gain_d = gain_code;
    end
  end

  // Temperature mode checks; the device only reports, software fixes
  // Both checks watch the raw inputs, so a gain change is seen at once
  always @* begin
    temp_amp_bad_d = temp_d && (amplifier_enable != `AMP_EN_TEMP);
    temp_gain_bad_d = temp_d && (gain_code > `GAIN_CODE_MAX_TEMP);
  end

  // Calibration average count from the two-bit code
  always @* begin
    case (cal_code)
      `CAL_CODE_1: cal_cnt_d = `CAL_CNT_1;
      `CAL_CODE_4: cal_cnt_d = `CAL_CNT_4;
      `CAL_CODE_8: cal_cnt_d = `CAL_CNT_8;
      `CAL_CODE_16: cal_cnt_d = `CAL_CNT_16;
      // All four codes are listed; the default only catches unknowns
      default: cal_cnt_d = `CAL_CNT_8;
    endcase
  end

  // Bias outputs, registered so each pin has a clean flop driver
  // Bit 7 is reserved and steers nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_to_input0 <= 1'b0;
      bias_to_input1 <= 1'b0;
      bias_to_input2 <= 1'b0;
      bias_to_input3 <= 1'b0;
      bias_to_input4 <= 1'b0;
      bias_to_input5 <= 1'b0;
      bias_to_common_input <= 1'b0;
    end else if (ce) begin
      bias_to_input0 <= bias_q[0];
      bias_to_input1 <= bias_q[1];
      bias_to_input2 <= bias_q[2];
      bias_to_input3 <= bias_q[3];
      bias_to_input4 <= bias_q[4];
      bias_to_input5 <= bias_q[5];
      bias_to_common_input <= bias_q[`BIAS_COMMON_BIT];
    end
  end

  // Monitor outputs; reset values match control register code 000
  // Every decoded output is a flop, so the analog side sees no glitch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_supply_short <= 1'b0;
      temp_sensor_route <= 1'b0;
      analog_supply_monitor <= 1'b0;
      digital_supply_monitor <= 1'b0;
      input_mux_open <= 1'b0;
      burnout_enable <= 1'b0;
      burnout_level <= `BURN_LVL_0U2;
      amplifier_enable_required <= 1'b0;
    end else if (ce) begin
      mid_supply_short <= mid_short_d;
      temp_sensor_route <= temp_d;
      analog_supply_monitor <= asup_d;
      digital_supply_monitor <= dsup_d;
      // Burn-out keeps the mux closed: the sources load the inputs
      input_mux_open <= mid_short_d || temp_d || asup_d || dsup_d;
      burnout_enable <= burn_en_d;
      burnout_level <= burn_lvl_d;
      amplifier_enable_required <= temp_d;
    end
  end

  // Gain, calibration and timeout outputs
  // Calibration count resets to eight to match the control default
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effective_gain_code <= `GAIN_CODE_ONE;
      calibration_sample_count <= `CAL_CNT_8;
      serial_timeout_enable <= 1'b0;
      temp_config_fault <= 1'b0;
      temp_amp_bad_q <= 1'b0;
      temp_gain_bad_q <= 1'b0;
    end else if (ce) begin
      effective_gain_code <= gain_d;
      calibration_sample_count <= cal_cnt_d;
      serial_timeout_enable <= timeout_bit;
      temp_config_fault <= temp_amp_bad_d || temp_gain_bad_d;
      temp_amp_bad_q <= temp_amp_bad_d;
      temp_gain_bad_q <= temp_gain_bad_d;
    end
  end

  // Status bits come from output flops, so a read reports them a clock
  // late; good enough for software polling, not for exact capture
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_TEMP_AMP_BIT] = temp_amp_bad_q;
    status_word[`ST_TEMP_GAIN_BIT] = temp_gain_bad_q;
    status_word[`ST_MUX_OPEN_BIT] = input_mux_open;
    status_word[`ST_GAIN_FORCED_BIT] = analog_supply_monitor ||
                                       digital_supply_monitor;
  end

  // Read data mux; unmapped and misaligned addresses read as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_bias) begin
      rdata_d[7:0] = bias_q;
    end else if (hit_sys) begin
      rdata_d[7:0] = sys_q;
    end else if (hit_rsvd) begin
      rdata_d[7:0] = `RST_RSVD_A;
    end else if (hit_status) begin
      rdata_d = status_word;
    end
  end

  // APB answer: one wait-free access phase, pready from a flop.
  // Trade-off: the setup edge preloads read data, so a read sees
  // the register state of that edge, not of the access edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      // Low ce holds the answer in place: the master sees wait states
      if (done) begin
        // Clearing here lets a back-to-back setup start from pready low
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end else if (start) begin
        pready <= 1'b1;
        // Writes to the reserved or status words are dropped quietly
        pslverr <= addr_error;
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      end
    end
  end

endmodule

`default_nettype wire

// ---- verilog/ctrl_reg.v ----
// Purpose: One software-written control register with a single write enable
// Assumes: Write enable is already qualified by decode and handshake
// Notes: Reset value is a parameter so each instance keeps its own
`timescale 1ns/1ps
`default_nettype none

module ctrl_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire we,
  input wire [WIDTH-1:0] wdata,
  output reg [WIDTH-1:0] value_q
);

  // Every bit is stored as written, reserved bits included
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RESET_VALUE;
    end else if (ce && we) begin
      value_q <= wdata;
    end
  end

endmodule

`default_nettype wire
